// ===== shared/acbe_consts.svh
// Offsets, field positions, encodings and reset values of the execution unit
`ifndef ACBE_CONSTS_SVH
`define ACBE_CONSTS_SVH

`define ACBE_REG_INSTR      8'h00
`define ACBE_REG_ACC        8'h04
`define ACBE_REG_STATUS     8'h08
`define ACBE_REG_BANK       8'h0c
`define ACBE_REG_PC         8'h10

`define ACBE_PC_W           21
`define ACBE_DM_AW          12
`define ACBE_BANK_W         4

`define ACBE_FLAG_C         0
`define ACBE_FLAG_DC        1
`define ACBE_FLAG_Z         2
`define ACBE_FLAG_OV        3
`define ACBE_FLAG_N         4
`define ACBE_STAT_BUSY      8

`define ACBE_ADD_LIT_HI     8'h0f
`define ACBE_AND_LIT_HI     8'h0b
`define ACBE_BR_CARRY_HI    8'he2
`define ACBE_ADD_REG_C_PFX  6'h08
`define ACBE_ADD_REG_PFX    6'h09
`define ACBE_AND_REG_PFX    6'h05
`define ACBE_DEST_BIT       9
`define ACBE_ACCESS_BIT     8

`define ACBE_ACCESS_BANK    4'h0
`define ACBE_RST_ACC        8'h00
`define ACBE_RST_FLAGS      5'h00
`define ACBE_RST_BANK       4'h0
`define ACBE_RST_PC         21'h000000
`define ACBE_PC_STEP        21'h000002

`endif

// ===== shared/acbe_pkg.sv
// Types shared by the execution unit files
package acbe_pkg;

  typedef enum logic [3:0] {
    PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4, PH_N1, PH_N2, PH_N3, PH_N4
  } acbe_phase_t;

  typedef enum logic [2:0] {
    NO_OP, ADD_LITERAL_OP, ADD_REGISTER_OP, ADD_REGISTER_CARRY_OP,
    AND_LITERAL_OP, AND_REGISTER_OP, BRANCH_ON_CARRY_OP
  } acbe_op_t;

endpackage : acbe_pkg

// ===== src/acbe_alu.sv
// Eight-bit add and AND datapath with flag generation
module acbe_alu (
  input  wire logic       isAnd,
  input  wire logic       useCarry,
  input  wire logic       carryIn,
  input  wire logic [7:0] accIn,
  input  wire logic [7:0] operand,
  output logic      [7:0] result,
  output logic            flagN,
  output logic            flagOv,
  output logic            flagZ,
  output logic            flagDc,
  output logic            flagC
);

  logic [8:0] sum;
  logic [4:0] lowSum;
  logic       cin;

  assign cin    = useCarry & carryIn;
  assign sum    = {1'b0, accIn} + {1'b0, operand} + {8'h00, cin};
  assign lowSum = {1'b0, accIn[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
  assign result = isAnd ? (accIn & operand) : sum[7:0];
  assign flagN  = result[7];
  assign flagZ  = (result == 8'h00);
  assign flagC  = sum[8];
  assign flagDc = lowSum[4];
  assign flagOv = (accIn[7] == operand[7]) && (sum[7] != accIn[7]);

endmodule : acbe_alu

// ===== src/acbe_exec_unit.sv
// Add, AND and carry-branch execution unit with a classic Wishbone register slave
//
// Contract
// [RULE1] Add literal runs in one four-phase cycle
// [RULE2] Add-with-carry sums accumulator, carry and register
// [RULE3] Add-with-carry decoded from prefix 0010 00
// [RULE4] Additions update N, OV, C, DC, Z
// [RULE5] Destination 0 writes accumulator, register untouched
// [RULE6] Destination 1 writes back to register
// [RULE7] Access bit 0 uses fixed bank
// [RULE8] Access bit 1 uses bank select pointer
// [RULE9] AND literal into accumulator, N and Z only
// [RULE10] AND literal decoded from upper byte 0000 1011
// [RULE11] AND register decoded from prefix 0001 01
// [RULE12] AND register destination 1 writes register
// [RULE13] AND register destination 0 writes accumulator
// [RULE14] Branch on carry decoded from 1110 0010
// [RULE15] Branch offset is signed eight bits
// [RULE16] Taken target is instruction address plus 2 plus 2n
// [RULE17] Taken branch two cycles, untaken one
// [RULE18] Offset doubled before adding to counter
// [RULE19] Add literal decoded from upper byte 0000 1111
// [RULE20] Add register decoded from prefix 0010 01
//
// Local design decisions: the address map and register access over Wishbone.
`include "acbe_consts.svh"

module acbe_exec_unit (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic      [`ACBE_DM_AW-1:0]   dmAddr,
  output logic                          dmRdEn,
  input  wire logic [7:0]               dmRdData,
  output logic                          dmWrEn,
  output logic      [7:0]               dmWrData,
  output logic                          busy,
  output logic                          instrDone
);

  acbe_pkg::acbe_phase_t phase;
  acbe_pkg::acbe_op_t    opKind;
  logic [15:0]             instrWord;
  logic [7:0]              acc;
  logic [4:0]              flags;
  logic [`ACBE_BANK_W-1:0] bankSel;
  logic [`ACBE_PC_W-1:0]   pc;
  logic [7:0]              operand;
  logic [7:0]              result;
  logic [4:0]              resFlags;
  logic                    destMem;
  logic                    branchTaken;
  logic                    wbWrite;
  logic                    startReq;
  logic                    isRegOp;
  logic                    isAluOp;
  logic [7:0]              aluRes;
  logic                    aluN;
  logic                    aluOv;
  logic                    aluZ;
  logic                    aluDc;
  logic                    aluC;
  logic [`ACBE_PC_W-1:0]   branchTarget;
  logic [`ACBE_PC_W-1:0]   seqNext;
  acbe_pkg::acbe_op_t      next_opKind;

  function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  sel);
    logic [31:0] mask;
    mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (oldVal & ~mask) | (newVal & mask);
  endfunction : mergeLanes

  // Bus slave: ack one cycle after the request, write at the edge that sees ack
  assign wbWrite  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign startReq = wbWrite && (wb_adr_i == `ACBE_REG_INSTR) && (phase == acbe_pkg::PH_IDLE);
  assign busy     = (phase != acbe_pkg::PH_IDLE);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      unique case (wb_adr_i)
        `ACBE_REG_INSTR:  wb_dat_o <= {16'h0000, instrWord};
        `ACBE_REG_ACC:    wb_dat_o <= {24'h000000, acc};
        `ACBE_REG_STATUS: wb_dat_o <= {23'h000000, busy, 3'h0, flags};
        `ACBE_REG_BANK:   wb_dat_o <= {28'h0000000, bankSel};
        `ACBE_REG_PC:     wb_dat_o <= {11'h000, pc};
        default:          wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Instruction word is loaded only while idle; a load starts execution
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instrWord <= 16'h0000;
    end else if (startReq) begin
      instrWord <= 16'(mergeLanes({16'h0000, instrWord}, wb_dat_i, wb_sel_i));
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bankSel <= `ACBE_RST_BANK;
    end else if (wbWrite && !busy && wb_adr_i == `ACBE_REG_BANK) begin
      bankSel <= `ACBE_BANK_W'(mergeLanes({28'h0000000, bankSel}, wb_dat_i, wb_sel_i));
    end
  end

  // Decode
  always_comb begin
    next_opKind = acbe_pkg::NO_OP;
    if (instrWord[15:8] == `ACBE_ADD_LIT_HI) begin
      next_opKind = acbe_pkg::ADD_LITERAL_OP;                     // [RULE19]
    end else if (instrWord[15:8] == `ACBE_AND_LIT_HI) begin
      next_opKind = acbe_pkg::AND_LITERAL_OP;                     // [RULE10]
    end else if (instrWord[15:8] == `ACBE_BR_CARRY_HI) begin
      next_opKind = acbe_pkg::BRANCH_ON_CARRY_OP;                 // [RULE14]
    end else if (instrWord[15:10] == `ACBE_ADD_REG_C_PFX) begin
      next_opKind = acbe_pkg::ADD_REGISTER_CARRY_OP;              // [RULE3]
    end else if (instrWord[15:10] == `ACBE_ADD_REG_PFX) begin
      next_opKind = acbe_pkg::ADD_REGISTER_OP;                    // [RULE20]
    end else if (instrWord[15:10] == `ACBE_AND_REG_PFX) begin
      next_opKind = acbe_pkg::AND_REGISTER_OP;                    // [RULE11]
    end
  end

  assign isRegOp = (opKind == acbe_pkg::ADD_REGISTER_OP) ||
                   (opKind == acbe_pkg::ADD_REGISTER_CARRY_OP) ||
                   (opKind == acbe_pkg::AND_REGISTER_OP);
  assign isAluOp = isRegOp || (opKind == acbe_pkg::ADD_LITERAL_OP) ||
                   (opKind == acbe_pkg::AND_LITERAL_OP);

  // Four phases per instruction cycle, plus four idle phases after a taken branch
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= acbe_pkg::PH_IDLE;
    end else begin
      unique case (phase)
        acbe_pkg::PH_IDLE: if (startReq) phase <= acbe_pkg::PH_Q1;
        acbe_pkg::PH_Q1:   phase <= acbe_pkg::PH_Q2;                // [RULE1]
        acbe_pkg::PH_Q2:   phase <= acbe_pkg::PH_Q3;
        acbe_pkg::PH_Q3:   phase <= acbe_pkg::PH_Q4;
        acbe_pkg::PH_Q4:   phase <= branchTaken ? acbe_pkg::PH_N1 : acbe_pkg::PH_IDLE; // [RULE17]
        acbe_pkg::PH_N1:   phase <= acbe_pkg::PH_N2;
        acbe_pkg::PH_N2:   phase <= acbe_pkg::PH_N3;
        acbe_pkg::PH_N3:   phase <= acbe_pkg::PH_N4;
        acbe_pkg::PH_N4:   phase <= acbe_pkg::PH_IDLE;
      endcase
    end
  end

  // Q1: decode and form the data memory address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      opKind  <= acbe_pkg::NO_OP;
      destMem <= 1'b0;
      dmAddr  <= '0;
    end else if (phase == acbe_pkg::PH_Q1) begin
      opKind  <= next_opKind;
      destMem <= instrWord[`ACBE_DEST_BIT];                       // [RULE5] [RULE6]
      if (instrWord[`ACBE_ACCESS_BIT]) begin
        dmAddr <= {bankSel, instrWord[7:0]};                      // [RULE8]
      end else begin
        dmAddr <= {`ACBE_ACCESS_BANK, instrWord[7:0]};            // [RULE7]
      end
    end
  end

  // Q2: read literal or register; memory answers in the same cycle
  assign dmRdEn = (phase == acbe_pkg::PH_Q2) && isRegOp;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      operand <= 8'h00;
    end else if (phase == acbe_pkg::PH_Q2) begin
      operand <= isRegOp ? dmRdData : instrWord[7:0];
    end
  end

  acbe_alu u_alu (
    .isAnd    ((opKind == acbe_pkg::AND_LITERAL_OP) || (opKind == acbe_pkg::AND_REGISTER_OP)),
    .useCarry (opKind == acbe_pkg::ADD_REGISTER_CARRY_OP),       // [RULE2]
    .carryIn  (flags[`ACBE_FLAG_C]),
    .accIn    (acc),
    .operand  (operand),
    .result   (aluRes),
    .flagN    (aluN),
    .flagOv   (aluOv),
    .flagZ    (aluZ),
    .flagDc   (aluDc),
    .flagC    (aluC)
  );

  // Q3: process data, prepare the register write for Q4
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      result   <= 8'h00;
      resFlags <= `ACBE_RST_FLAGS;
      dmWrEn   <= 1'b0;
      dmWrData <= 8'h00;
    end else begin
      dmWrEn <= (phase == acbe_pkg::PH_Q3) && isRegOp && destMem;  // [RULE6] [RULE12]
      if (phase == acbe_pkg::PH_Q3) begin
        result   <= aluRes;
        dmWrData <= aluRes;
        resFlags <= {aluN, aluOv, aluZ, aluDc, aluC};
      end
    end
  end

  // Q4: write accumulator and flags
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= `ACBE_RST_ACC;
    end else if (phase == acbe_pkg::PH_Q4 && isAluOp && !(isRegOp && destMem)) begin
      acc <= result;                                              // [RULE1] [RULE5] [RULE13]
    end else if (wbWrite && !busy && wb_adr_i == `ACBE_REG_ACC) begin
      acc <= 8'(mergeLanes({24'h000000, acc}, wb_dat_i, wb_sel_i));
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= `ACBE_RST_FLAGS;
    end else if (phase == acbe_pkg::PH_Q4 && isAluOp) begin
      if ((opKind == acbe_pkg::AND_LITERAL_OP) || (opKind == acbe_pkg::AND_REGISTER_OP)) begin
        flags[`ACBE_FLAG_N] <= resFlags[`ACBE_FLAG_N];              // [RULE9]
        flags[`ACBE_FLAG_Z] <= resFlags[`ACBE_FLAG_Z];
      end else begin
        flags <= resFlags;                                        // [RULE4]
      end
    end else if (wbWrite && !busy && wb_adr_i == `ACBE_REG_STATUS) begin
      flags <= 5'(mergeLanes({27'h0000000, flags}, wb_dat_i, wb_sel_i));
    end
  end

  // Program counter holds the address of the instruction in execution
  assign branchTaken  = (opKind == acbe_pkg::BRANCH_ON_CARRY_OP) && flags[`ACBE_FLAG_C]; // [RULE14]
  assign seqNext      = pc + `ACBE_PC_STEP;
  assign branchTarget = seqNext + {{12{operand[7]}}, operand, 1'b0}; // [RULE15] [RULE16] [RULE18]

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pc <= `ACBE_RST_PC;
    end else if (phase == acbe_pkg::PH_Q4) begin
      pc <= branchTaken ? branchTarget : seqNext;                 // [RULE16] [RULE17]
    end else if (wbWrite && !busy && wb_adr_i == `ACBE_REG_PC) begin
      pc <= `ACBE_PC_W'(mergeLanes({11'h000, pc}, wb_dat_i, wb_sel_i));
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instrDone <= 1'b0;
    end else begin
      instrDone <= ((phase == acbe_pkg::PH_Q4) && !branchTaken) || (phase == acbe_pkg::PH_N4);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_phase_order: assert property (phase == acbe_pkg::PH_Q1 |=>           // [RULE1]
      phase == acbe_pkg::PH_Q2 ##1 phase == acbe_pkg::PH_Q3 ##1 phase == acbe_pkg::PH_Q4)
    else $error("instruction phases out of order");
  a_taken_nop_cycle: assert property (phase == acbe_pkg::PH_Q4 && branchTaken |=> // [RULE17]
      (!dmWrEn && !dmRdEn) [*4] ##1 phase == acbe_pkg::PH_IDLE)
    else $error("taken branch not followed by one idle cycle");
  a_untaken_one_cycle: assert property (                                  // [RULE17]
      phase == acbe_pkg::PH_Q4 && opKind == acbe_pkg::BRANCH_ON_CARRY_OP && !branchTaken
      |=> phase == acbe_pkg::PH_IDLE && pc == $past(pc) + `ACBE_PC_STEP)
    else $error("untaken branch altered flow");
  a_branch_target_calc: assert property (phase == acbe_pkg::PH_Q4 && branchTaken |=> // [RULE16]
      pc == $past(pc) + `ACBE_PC_STEP + {{12{$past(operand[7])}}, $past(operand), 1'b0})
    else $error("branch target wrong");
  a_dest_zero_no_write: assert property (dmWrEn |-> isRegOp && destMem)  // [RULE5]
    else $error("memory written with destination zero");
  a_dest_one_write: assert property (phase == acbe_pkg::PH_Q3 && isRegOp && destMem // [RULE6]
      |=> dmWrEn && dmWrData == $past(aluRes) ##1 !dmWrEn)
    else $error("write back missing");
  a_bank_address: assert property (phase == acbe_pkg::PH_Q1 |=>          // [RULE7] [RULE8]
      dmAddr[11:8] == ($past(instrWord[`ACBE_ACCESS_BIT]) ? $past(bankSel) : `ACBE_ACCESS_BANK))
    else $error("data memory bank wrong");
  a_add_carry_sum: assert property (phase == acbe_pkg::PH_Q3 &&          // [RULE2]
      opKind == acbe_pkg::ADD_REGISTER_CARRY_OP |=>
      result == 8'(acc + operand + {7'h00, flags[`ACBE_FLAG_C]}))
    else $error("add with carry sum wrong");
  a_and_flags_kept: assert property (phase == acbe_pkg::PH_Q4 &&         // [RULE9]
      (opKind == acbe_pkg::AND_LITERAL_OP || opKind == acbe_pkg::AND_REGISTER_OP) |=>
      flags[`ACBE_FLAG_C] == $past(flags[`ACBE_FLAG_C]) &&
      flags[`ACBE_FLAG_OV] == $past(flags[`ACBE_FLAG_OV]) &&
      flags[`ACBE_FLAG_DC] == $past(flags[`ACBE_FLAG_DC]))
    else $error("AND touched arithmetic flags");

endmodule : acbe_exec_unit

// ===== sim/tb_top.sv
// Self-checking bench for the add, AND and carry-branch execution unit
`include "acbe_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

  logic        sysClk    = 1'b0;
  logic        rstn      = 1'b0;
  logic        wbCyc     = 1'b0;
  logic        wbStb     = 1'b0;
  logic        wbWe      = 1'b0;
  logic [7:0]  wbAdr     = 8'h00;
  logic [3:0]  wbSel     = 4'h0;
  logic [31:0] wbDatI    = 32'h0;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic [11:0] dmAddr;
  logic        dmRdEn;
  logic [7:0]  dmRdData;
  logic        dmWrEn;
  logic [7:0]  dmWrData;
  logic        busy;
  logic        instrDone;
  logic [7:0]  mem [0:4095];
  int          errors    = 0;
  int          numChecks = 0;

  always #2 sysClk = ~sysClk;

  acbe_exec_unit acbe_exec_unit_i (
    .sys_clk  (sysClk),
    .rstn     (rstn),
    .wb_cyc_i (wbCyc),
    .wb_stb_i (wbStb),
    .wb_we_i  (wbWe),
    .wb_adr_i (wbAdr),
    .wb_sel_i (wbSel),
    .wb_dat_i (wbDatI),
    .wb_dat_o (wbDatO),
    .wb_ack_o (wbAck),
    .dmAddr   (dmAddr),
    .dmRdEn   (dmRdEn),
    .dmRdData (dmRdData),
    .dmWrEn   (dmWrEn),
    .dmWrData (dmWrData),
    .busy     (busy),
    .instrDone(instrDone)
  );

  // Outside a read strobe the memory shows the inverse, so a stray sample is caught
  assign dmRdData = dmRdEn ? mem[dmAddr] : ~mem[dmAddr];

  always @(posedge sysClk) begin
    if (dmWrEn === 1'b1) begin
      mem[dmAddr] <= dmWrData;
    end
  end

  task automatic report_and_stop;
    $display("Checks: %0d, errors: %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge sysClk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatI <= d;
    wbSel  <= 4'hf;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge sysClk);
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(1'b0, a, 32'h0, q);
  endtask : rd

  // Expected architectural state after one instruction
  function automatic void model(input logic [15:0] ins, input logic [7:0] a,
      input logic [4:0] fl, input logic [7:0] m, input logic [20:0] pc,
      output logic [7:0] eA, output logic [4:0] eF, output logic [7:0] eM,
      output logic [20:0] eP, output int cyc);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b;
    logic [7:0] r;
    logic       cin;
    logic       isAdd;
    logic       isAnd;
    logic       isReg;
    b = ins[7:0];
    eA = a;
    eF = fl;
    eM = m;
    eP = pc + 21'h2;
    cyc = 5;
    isReg = ins[15:10] inside {6'h08, 6'h09, 6'h05};
    isAdd = (ins[15:8] == 8'h0f) || (ins[15:11] == 5'b00100);
    isAnd = (ins[15:8] == 8'h0b) || (ins[15:10] == 6'h05);
    cin = (ins[15:10] == 6'h08) & fl[0];
    if (isReg) begin
      b = m;
    end
    if (ins[15:8] == 8'he2 && fl[0]) begin
      eP = pc + 21'h2 + {{12{b[7]}}, b, 1'b0};
      cyc = 9;
    end
    r = a & b;
    if (isAdd) begin
      s = {1'b0, a} + {1'b0, b} + {8'h0, cin};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      r = s[7:0];
      eF = {r[7], (a[7] == b[7]) && (r[7] != a[7]), r == 8'h0, h[4], s[8]};
    end
    if (isAnd) begin
      eF[4] = r[7];
      eF[2] = (r == 8'h0);
    end
    if (isAdd || isAnd) begin
      if (isReg && ins[9]) begin
        eM = r;
      end else begin
        eA = r;
      end
    end
  endfunction : model

  task automatic run(input logic [15:0] ins, input logic [7:0] a, input logic [4:0] fl,
                     input logic [3:0] bk, input logic [7:0] m, input logic [20:0] pc);
    logic [11:0] ad;
    logic [11:0] rdAd;
    logic [31:0] q;
    logic [7:0]  eA;
    logic [7:0]  eM;
    logic [4:0]  eF;
    logic [20:0] eP;
    logic        busy1;
    logic        isReg;
    int          cyc;
    int          n;
    int          nWr;
    isReg = ins[15:10] inside {6'h08, 6'h09, 6'h05};
    ad = {ins[8] ? bk : 4'h0, ins[7:0]};
    mem[ad] = m;
    rdAd = ~ad;
    model(ins, a, fl, m, pc, eA, eF, eM, eP, cyc);
    wr(`ACBE_REG_ACC, {24'h0, a});
    wr(`ACBE_REG_STATUS, {27'h0, fl});
    wr(`ACBE_REG_BANK, {28'h0, bk});
    wr(`ACBE_REG_PC, {11'h0, pc});
    wr(`ACBE_REG_INSTR, {16'h0, ins});
    n = 0;
    nWr = 0;
    busy1 = 1'b0;
    do begin
      @(posedge sysClk);
      n++;
      if (n == 1) busy1 = busy;
      if (dmRdEn === 1'b1) rdAd = dmAddr;
      if (dmWrEn === 1'b1) nWr++;
    end while (instrDone !== 1'b1 && n < 20);
    `CHK(n, cyc)
    `CHK(busy1, 1'b1)
    rd(`ACBE_REG_ACC, q);
    `CHK(q[7:0], eA)
    rd(`ACBE_REG_STATUS, q);
    `CHK(q[8:0], {4'h0, eF})
    rd(`ACBE_REG_PC, q);
    `CHK(q[20:0], eP)
    `CHK(mem[ad], eM)
    `CHK(nWr, (isReg && ins[9]) ? 1 : 0)
    if (isReg) `CHK(rdAd, ad)
  endtask : run

  initial begin
    #100000;
    errors++;
    report_and_stop();
  end

  initial begin
    logic [15:0] ins;
    logic [31:0] q;
    void'($urandom(32'h6ca2));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (2) @(posedge sysClk);
    rstn <= 1'b1;
    rd(`ACBE_REG_BANK, q);
    `CHK(q, 32'h0)
    rd(`ACBE_REG_ACC, q);
    `CHK(q, 32'h0)
    rd(`ACBE_REG_STATUS, q);
    `CHK(q, 32'h0)
    rd(`ACBE_REG_PC, q);
    `CHK(q, 32'h0)
    run(16'h0f15, 8'h10, 5'h00, 4'h3, 8'h00, 21'h000100);
    run(16'h0b5f, 8'ha3, 5'h1b, 4'h3, 8'h00, 21'h000100);
    run(16'h2142, 8'h4d, 5'h01, 4'h5, 8'h02, 21'h000200);
    run(16'h2433, 8'h17, 5'h01, 4'h5, 8'hc2, 21'h000200);
    run(16'h2733, 8'h7f, 5'h00, 4'h6, 8'h01, 21'h000300);
    run(16'h1433, 8'h17, 5'h00, 4'h7, 8'hc2, 21'h000300);
    run(16'h1733, 8'hf0, 5'h00, 4'h9, 8'h0f, 21'h000400);
    run(16'h0f01, 8'hff, 5'h18, 4'h0, 8'h00, 21'h000400);
    run(16'he280, 8'h00, 5'h01, 4'h0, 8'h00, 21'h000100);
    run(16'he27f, 8'h00, 5'h01, 4'h0, 8'h00, 21'h1ffff0);
    run(16'he27f, 8'h00, 5'h1e, 4'h0, 8'h00, 21'h000500);
    run(16'hffff, 8'h33, 5'h05, 4'h0, 8'h00, 21'h000600);
    for (int i = 0; i < 60; i++) begin
      ins = 16'($urandom);
      case ($urandom % 7)
        0: ins[15:8] = 8'h0f;
        1: ins[15:8] = 8'h0b;
        2: ins[15:8] = 8'he2;
        3: ins[15:10] = 6'h08;
        4: ins[15:10] = 6'h09;
        5: ins[15:10] = 6'h05;
        default: ins = ins;
      endcase
      run(ins, 8'($urandom), 5'($urandom), 4'($urandom), 8'($urandom),
          {20'($urandom), 1'b0});
    end
    rd(8'h20, q);
    `CHK(q, 32'h0)
    wr(`ACBE_REG_ACC, 32'h0000005a);
    rd(`ACBE_REG_ACC, q);
    `CHK(q, 32'h0000005a)
    // Reset lands while an instruction is in flight
    wr(`ACBE_REG_INSTR, 32'h00000f01);
    @(posedge sysClk);
    rstn <= 1'b0;
    @(posedge sysClk);
    rstn <= 1'b1;
    rd(`ACBE_REG_ACC, q);
    `CHK(q, 32'h0)
    `CHK(busy, 1'b0)
    `CHK(instrDone, 1'b0)
    report_and_stop();
  end

endmodule : tb_top
